// ### rtl/option_regs.sv
// Option configuration words, their command port and the logic they steer
`timescale 1ns/100ps
`include "option_regs_consts.svh"
module option_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire option_regs_pkg::link_cmd_t link_cmd,
  output logic link_ready,
  output option_regs_pkg::link_rsp_t link_rsp,
  input wire logic power_good_out_raw,
  input wire logic reset_req_raw,
  output logic reset_or_good_pin,
  output logic telemetry_adc_enable,
  output logic voltage_only_measure,
  input wire option_regs_pkg::sample_t sample_in,
  output option_regs_pkg::telemetry_t readings,
  input wire logic [1:0] vout_scale_loop,
  output option_regs_pkg::divider_t vout_adc_divider_select,
  output logic limit_override,
  input wire logic write_check_fail,
  input wire logic clear_faults,
  output logic invalid_data_flag,
  input wire logic [7:0] fault_active,
  input wire logic [7:0] host_mask_set,
  input wire logic ara_done,
  output logic [7:0] fault_mask,
  output logic smbalert_active,
  input wire logic shutdown_event,
  output logic vout_command_restore,
  output logic [15:0] margin_low_restore,
  output logic [15:0] margin_high_restore,
  output logic negative_limit_disable,
  output option_regs_pkg::misc_t misc_options
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [2:0] depth_log2(input logic [1:0] code);
    case (code)
      `AVG_16: depth_log2 = 3'h4;
      `AVG_BYPASS: depth_log2 = 3'h0;
      `AVG_8: depth_log2 = 3'h3;
      `AVG_32: depth_log2 = 3'h5;
      default: depth_log2 = 3'h4;
    endcase
  endfunction

  function automatic option_regs_pkg::divider_t pick_divider(
    input logic [1:0] range, input logic [1:0] scale);
    case (range)
      `RANGE_2: pick_divider = option_regs_pkg::DIV_2;
      `RANGE_4: pick_divider = option_regs_pkg::DIV_4;
      `RANGE_8: pick_divider = option_regs_pkg::DIV_8;
      default: begin
        case (scale)
          `SCALE_HALF: pick_divider = option_regs_pkg::DIV_4;
          `SCALE_QTR: pick_divider = option_regs_pkg::DIV_8;
          default: pick_divider = option_regs_pkg::DIV_2;
        endcase
      end
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Link side: command capture and answer
  // ---------------------------------------------------------------
  option_regs_pkg::link_state_t lstate_reg;
  option_regs_pkg::link_cmd_t hold_reg;
  logic req_tog_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic ack_s3_reg;
  logic ack_event;

  // Core-side answer, held stable until the next request
  logic ack_tog_reg;
  logic rsp_nack_reg;
  logic [15:0] rsp_data_reg;

  assign link_ready = (lstate_reg == option_regs_pkg::L_IDLE);
  assign ack_event = ack_s2_reg ^ ack_s3_reg;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tog_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lstate_reg <= option_regs_pkg::L_IDLE;
      hold_reg <= '0;
      req_tog_reg <= 1'b0;
    end else begin
      case (lstate_reg)
        option_regs_pkg::L_IDLE: begin
          if (link_cmd.valid) begin
            hold_reg <= link_cmd;
            req_tog_reg <= ~req_tog_reg;
            lstate_reg <= option_regs_pkg::L_WAIT;
          end
        end
        option_regs_pkg::L_WAIT: begin
          if (ack_event) begin
            lstate_reg <= option_regs_pkg::L_IDLE;
          end
        end
        default: lstate_reg <= option_regs_pkg::L_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_rsp <= '0;
    end else begin
      link_rsp.valid <= ack_event;
      if (ack_event) begin
        link_rsp.nack <= rsp_nack_reg;
        link_rsp.data <= rsp_data_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Core side: request crossing and pin synchronisers
  // ---------------------------------------------------------------
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic req_event;
  logic pg_s1_reg;
  logic pg_s2_reg;
  logic rr_s1_reg;
  logic rr_s2_reg;

  assign req_event = req_s2_reg ^ req_s3_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      pg_s1_reg <= 1'b0;
      pg_s2_reg <= 1'b0;
      rr_s1_reg <= 1'b0;
      rr_s2_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tog_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      pg_s1_reg <= power_good_out_raw;
      pg_s2_reg <= pg_s1_reg;
      rr_s1_reg <= reset_req_raw;
      rr_s2_reg <= rr_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Option words and their saved copies
  // ---------------------------------------------------------------
  logic [15:0] opt_reg;
  logic [15:0] misc_reg;
  logic [15:0] nv_opt_reg;
  logic [15:0] nv_misc_reg;
  logic wr_cmd;
  logic rd_cmd;

  assign wr_cmd = req_event && hold_reg.write;
  assign rd_cmd = req_event && !hold_reg.write;

  // Undefined bits are masked off on every path into the words
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opt_reg <= `OPT_RESET;
      misc_reg <= `MISC_RESET;
    end else if (wr_cmd) begin
      case (hold_reg.code)
        `CMD_OPTIONS: opt_reg <= hold_reg.wdata & `OPT_WMASK;
        `CMD_MISC: misc_reg <= hold_reg.wdata & `MISC_WMASK;
        `CMD_RESTORE_ALL: begin
          // Unbacked bits keep their live value
          opt_reg <= (opt_reg & ~`OPT_NV_MASK) | nv_opt_reg;
          misc_reg <= nv_misc_reg;
        end
        default: opt_reg <= opt_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_opt_reg <= `OPT_RESET & `OPT_NV_MASK;
      nv_misc_reg <= `MISC_RESET;
    end else if (wr_cmd && hold_reg.code == `CMD_STORE_ALL) begin
      nv_opt_reg <= opt_reg & `OPT_NV_MASK;
      nv_misc_reg <= misc_reg;
    end
  end

  // ---------------------------------------------------------------
  // Answer to the link
  // ---------------------------------------------------------------
  logic known_rd;
  logic known_wr;

  assign known_rd = hold_reg.code inside {`CMD_OPTIONS, `CMD_MISC, `CMD_READ_VOUT, `CMD_READ_IOUT, `CMD_READ_TEMP};
  assign known_wr = hold_reg.code inside {`CMD_OPTIONS, `CMD_MISC, `CMD_STORE_ALL, `CMD_RESTORE_ALL};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_tog_reg <= 1'b0;
      rsp_nack_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
    end else if (req_event) begin
      ack_tog_reg <= ~ack_tog_reg;
      rsp_nack_reg <= hold_reg.write ? !known_wr : !known_rd;
      if (rd_cmd) begin
        case (hold_reg.code)
          `CMD_OPTIONS: rsp_data_reg <= opt_reg;
          `CMD_MISC: rsp_data_reg <= misc_reg;
          `CMD_READ_VOUT: rsp_data_reg <= readings.vout;
          `CMD_READ_IOUT: rsp_data_reg <= readings.iout;
          `CMD_READ_TEMP: rsp_data_reg <= readings.temp;
          default: rsp_data_reg <= 16'h0000;
        endcase
      end else begin
        rsp_data_reg <= 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Shared reset / power-good pin
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_or_good_pin <= 1'b0;
    end else if (opt_reg[`OPT_RESET_B]) begin
      reset_or_good_pin <= ~rr_s2_reg;
    end else begin
      reset_or_good_pin <= pg_s2_reg;
    end
  end

  // ---------------------------------------------------------------
  // Telemetry
  // ---------------------------------------------------------------
  logic vsm_d_reg;
  logic vsm_change;
  logic adc_on;
  logic vsm_on;
  logic [2:0] depth;
  logic [2:0] ch_valid;
  logic [15:0] ch_data [3];

  assign adc_on = opt_reg[`OPT_ADC];
  assign vsm_on = opt_reg[`OPT_VSM];
  assign depth = depth_log2(opt_reg[`OPT_AVG +: 2]);
  assign vsm_change = vsm_on ^ vsm_d_reg;
  assign telemetry_adc_enable = adc_on;
  assign voltage_only_measure = vsm_on;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vsm_d_reg <= 1'b0;
    end else begin
      vsm_d_reg <= vsm_on;
    end
  end

  // Blocked samples leave the readings held
  assign ch_valid[0] = sample_in.valid && adc_on && sample_in.kind == `CH_VOUT;
  assign ch_valid[1] = sample_in.valid && adc_on && !vsm_on && sample_in.kind == `CH_IOUT;
  assign ch_valid[2] = sample_in.valid && adc_on && !vsm_on && sample_in.kind == `CH_TEMP;

  for (genvar k = 0; k < 3; k++) begin : g_avg
    telemetry_averager u_avg (
      .clk(clk),
      .reset_n(reset_n),
      .restart((k == 0) && vsm_change),
      .depth_log2(depth),
      .in_valid(ch_valid[k]),
      .in_data(sample_in.data),
      .out_data(ch_data[k])
    );
  end

  assign readings = {ch_data[0], ch_data[1], ch_data[2]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vout_adc_divider_select <= option_regs_pkg::DIV_2;
    end else begin
      vout_adc_divider_select <= pick_divider(opt_reg[`OPT_RANGE +: 2], vout_scale_loop);
    end
  end

  // ---------------------------------------------------------------
  // Invalid data and alert
  // ---------------------------------------------------------------
  assign limit_override = opt_reg[`OPT_DLO];

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      invalid_data_flag <= 1'b0;
    end else begin
      invalid_data_flag <= (invalid_data_flag && !clear_faults) ||
                           (write_check_fail && !opt_reg[`OPT_DLO]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_mask <= 8'h00;
    end else begin
      fault_mask <= (clear_faults ? 8'h00 : fault_mask) | host_mask_set |
                    ((ara_done && opt_reg[`OPT_ARA]) ? fault_active : 8'h00);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      smbalert_active <= 1'b0;
    end else begin
      smbalert_active <= |(fault_active & ~fault_mask) || invalid_data_flag;
    end
  end

  // ---------------------------------------------------------------
  // Shutdown restore and margin restore values
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vout_command_restore <= 1'b0;
    end else begin
      vout_command_restore <= shutdown_event && opt_reg[`OPT_RSTVOUT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      margin_low_restore <= `MLO_VAL0;
      margin_high_restore <= `MHI_VAL0;
    end else begin
      margin_low_restore <= opt_reg[`OPT_RSMLO] ? `MLO_VAL1 : `MLO_VAL0;
      margin_high_restore <= opt_reg[`OPT_RSMHI] ? `MHI_VAL1 : `MHI_VAL0;
    end
  end

  // ---------------------------------------------------------------
  // Option bits driven straight from the words
  // ---------------------------------------------------------------
  assign negative_limit_disable = opt_reg[`OPT_NEGILIM];
  assign misc_options = {misc_reg[`MISC_SYNC_DIS], misc_reg[`MISC_SYNC_IN], misc_reg[`MISC_SYNC_OUT],
                         misc_reg[`MISC_LVLSH], misc_reg[`MISC_TRIM +: 2], misc_reg[`MISC_OVRESP]};

endmodule

// ### rtl/option_regs_consts.svh
// Command codes, option word layouts, reset values and restore constants
//
// What this block does
// - Shared pin shows power good when pin-function bit is 0, active-low reset when 1.
// - Telemetry ADC runs only while the ADC-enable bit is 1.
// - With ADC disabled, readings freeze at their last values.
// - Voltage-only bit stops current and temperature updates; not saved to nonvolatile.
// - First voltage average after voltage-only change may miss one sample.
// - Limit-override bit skips valid-data checks on writes; not saved to nonvolatile.
// - Invalid data taken under override never sets invalid flag nor raises alert.
// - Averaging field: 00 gives 16x, 01 bypass, 10 gives 8x, 11 gives 32x.
// - In bypass each sample updates its reading directly; the first after a mid-window depth change adds the leftover sum.
// - Saved averaging depth is restored, not a fixed value.
// - Auto alert response masks all active faults after an answered alert address.
// - Without auto response faults reassert alert; host masks sources one by one.
// - Range field picks vout divider; 00 follows loop scale.
// - Reset-output-command bit restores output command on shutdown events.
// - Low-margin select restores FFF7 when 0, FFF1 when 1.
// - High-margin select restores 0009 when 0, 000F when 1.
// - Misc word writable in defined bits, savable to nonvolatile memory.
// - Options word savable to nonvolatile memory except unbacked bits.
`ifndef OPTION_REGS_CONSTS_SVH
`define OPTION_REGS_CONSTS_SVH

`define CMD_STORE_ALL 8'h11
`define CMD_RESTORE_ALL 8'h12
`define CMD_READ_VOUT 8'h8B
`define CMD_READ_IOUT 8'h8C
`define CMD_READ_TEMP 8'h8D
`define CMD_OPTIONS 8'hE5
`define CMD_MISC 8'hF0

`define OPT_RESET 16'h0084
`define OPT_WMASK 16'h6BFF
`define OPT_NV_MASK 16'h6BE7
`define MISC_RESET 16'h0193
`define MISC_WMASK 16'h01D7

`define OPT_NEGILIM 0
`define OPT_RESET_B 1
`define OPT_ADC 2
`define OPT_VSM 3
`define OPT_DLO 4
`define OPT_AVG 5
`define OPT_ARA 7
`define OPT_RANGE 8
`define OPT_RSTVOUT 11
`define OPT_RSMLO 13
`define OPT_RSMHI 14

`define MISC_OVRESP 0
`define MISC_TRIM 1
`define MISC_LVLSH 4
`define MISC_SYNC_OUT 6
`define MISC_SYNC_IN 7
`define MISC_SYNC_DIS 8

`define MLO_VAL0 16'hFFF7
`define MLO_VAL1 16'hFFF1
`define MHI_VAL0 16'h0009
`define MHI_VAL1 16'h000F

`define AVG_16 2'h0
`define AVG_BYPASS 2'h1
`define AVG_8 2'h2
`define AVG_32 2'h3
`define RANGE_LOOP 2'h0
`define RANGE_8 2'h1
`define RANGE_4 2'h2
`define RANGE_2 2'h3
`define SCALE_1 2'h0
`define SCALE_HALF 2'h1
`define SCALE_QTR 2'h2

`define CH_VOUT 2'h0
`define CH_IOUT 2'h1
`define CH_TEMP 2'h2

`endif

// ### rtl/option_regs_pkg.sv
// Types shared by the option register block
package option_regs_pkg;

  typedef enum logic [1:0] {
    DIV_2 = 2'h0,
    DIV_4 = 2'h1,
    DIV_8 = 2'h3
  } divider_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'h0,
    L_WAIT = 2'h1
  } link_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } link_cmd_t;

  typedef struct packed {
    logic valid;
    logic nack;
    logic [15:0] data;
  } link_rsp_t;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [15:0] data;
  } sample_t;

  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp;
  } telemetry_t;

  typedef struct packed {
    logic sync_fault_disable;
    logic force_sync_in;
    logic force_sync_out;
    logic level_shifter_enable;
    logic [1:0] overcurrent_trim;
    logic overvoltage_response_select;
  } misc_t;

endpackage

// ### rtl/telemetry_averager.sv
// Accumulate-and-average filter for one telemetry channel
`timescale 1ns/100ps
module telemetry_averager (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic [2:0] depth_log2,
  input wire logic in_valid,
  input wire logic [15:0] in_data,
  output logic [15:0] out_data
);

  logic [20:0] acc_reg;
  logic [5:0] cnt_reg;
  logic [20:0] sum;
  logic [20:0] mean;
  logic [5:0] last_idx;
  logic last;

  assign sum = acc_reg + {5'h00, in_data};
  assign mean = sum >> depth_log2;
  assign last_idx = 6'((7'h01 << depth_log2) - 7'h01);
  assign last = (depth_log2 == 3'h0) || (cnt_reg == last_idx);

  // ---------------------------------------------------------------
  // Accumulator
  // ---------------------------------------------------------------
  // A restart drops the partial sum; a window completing in the restart cycle still loads its result, later results cover only newer samples
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= 21'h000000;
      cnt_reg <= 6'h00;
    end else if (restart) begin
      acc_reg <= 21'h000000;
      cnt_reg <= 6'h00;
    end else if (in_valid) begin
      if (last) begin
        acc_reg <= 21'h000000;
        cnt_reg <= 6'h00;
      end else begin
        acc_reg <= sum;
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_data <= 16'h0000;
    end else if (in_valid && last) begin
      out_data <= mean[15:0];
    end
  end

endmodule

// ### tb/option_regs_monitor.sv
// Assertion checker for the option register block
`timescale 1ns/100ps
module option_regs_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire option_regs_pkg::link_cmd_t link_cmd,
  input wire logic link_ready,
  input wire option_regs_pkg::link_rsp_t link_rsp,
  input wire logic telemetry_adc_enable,
  input wire logic voltage_only_measure,
  input wire option_regs_pkg::telemetry_t readings,
  input wire logic limit_override,
  input wire logic write_check_fail,
  input wire logic invalid_data_flag,
  input wire logic [7:0] host_mask_set,
  input wire logic [7:0] fault_mask,
  input wire logic smbalert_active,
  input wire logic shutdown_event,
  input wire logic vout_command_restore,
  input wire logic [15:0] margin_low_restore,
  input wire logic [15:0] margin_high_restore
);
  // ----------------
  // Link domain
  // ----------------
  AST_LINK_BUSY: assert property (@(posedge link_clk) disable iff (!reset_n)
    link_cmd.valid && link_ready |=> !link_ready ##[1:12] link_rsp.valid) else $error("link answer missing");
  AST_RSP_PULSE: assert property (@(posedge link_clk) disable iff (!reset_n)
    link_rsp.valid |=> !link_rsp.valid) else $error("answer longer than one cycle");
  // ----------------
  // Core domain, plus the link-clocked COV_NACK cover
  // ----------------
  AST_ADC_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(telemetry_adc_enable) |-> $stable(readings)) else $error("reading moved with adc off");
  AST_VSM_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    $past(voltage_only_measure) |-> $stable({readings.iout, readings.temp})) else $error("iout or temp moved");
  AST_IVD_SET: assert property (@(posedge clk) disable iff (!reset_n)
    write_check_fail && !limit_override |=> invalid_data_flag) else $error("invalid flag not set");
  AST_IVD_DLO: assert property (@(posedge clk) disable iff (!reset_n)
    !invalid_data_flag && !(write_check_fail && !limit_override) |=> !invalid_data_flag)
    else $error("invalid flag set under override");
  AST_ALERT_IVD: assert property (@(posedge clk) disable iff (!reset_n)
    invalid_data_flag |=> smbalert_active) else $error("alert missing for invalid data");
  AST_HOST_MASK: assert property (@(posedge clk) disable iff (!reset_n)
    |host_mask_set |=> (fault_mask & $past(host_mask_set)) == $past(host_mask_set)) else $error("host mask lost");
  AST_RESTORE: assert property (@(posedge clk) disable iff (!reset_n)
    vout_command_restore |-> $past(shutdown_event)) else $error("restore pulse without event");
  AST_MARGIN_LO: assert property (@(posedge clk) disable iff (!reset_n)
    margin_low_restore inside {16'hFFF7, 16'hFFF1}) else $error("bad low margin restore");
  AST_MARGIN_HI: assert property (@(posedge clk) disable iff (!reset_n)
    margin_high_restore inside {16'h0009, 16'h000F}) else $error("bad high margin restore");
  COV_NACK: cover property (@(posedge link_clk) disable iff (!reset_n) link_rsp.valid && link_rsp.nack);
  COV_IVD: cover property (@(posedge clk) disable iff (!reset_n) $rose(invalid_data_flag));
  COV_RESTORE: cover property (@(posedge clk) disable iff (!reset_n) vout_command_restore);
endmodule

bind option_regs option_regs_monitor mon (.*);

// ### tb/link_host_model.sv
// Host side of the command link
`timescale 1ns/100ps
module link_host_model (
  input wire logic link_clk,
  input wire logic link_ready,
  input wire option_regs_pkg::link_rsp_t link_rsp,
  output option_regs_pkg::link_cmd_t link_cmd
);
  initial link_cmd = '0;
  // One command held until taken, then a bounded wait for its answer
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic nack);
    int n = 0;
    @(negedge link_clk);
    while (!link_ready) @(negedge link_clk);
    link_cmd = {1'b1, wr, code, wd};
    @(negedge link_clk);
    link_cmd = {1'b0, ~wr, ~code, ~wd};
    while (!link_rsp.valid && n < 20) begin
      @(negedge link_clk);
      n++;
    end
    rd = link_rsp.data;
    nack = link_rsp.valid ? link_rsp.nack : 1'bx;
  endtask
endmodule

// ### tb/pmbus_option_config_regs_test.sv
// Self-checking bench for the option register block
`timescale 1ns/100ps
`include "option_regs_consts.svh"
module pmbus_option_config_regs_test;
  logic clk = 0, reset_n = 0, link_clk = 0, power_good_out_raw = 0, reset_req_raw = 0, write_check_fail = 0;
  logic clear_faults = 0, ara_done = 0, shutdown_event = 0, link_ready, reset_or_good_pin;
  logic telemetry_adc_enable, voltage_only_measure, limit_override, invalid_data_flag;
  logic smbalert_active, vout_command_restore, negative_limit_disable, nack;
  logic [1:0] vout_scale_loop = 0;
  logic [7:0] fault_active = 0, host_mask_set = 0, fault_mask;
  logic [15:0] margin_low_restore, margin_high_restore, rd;
  option_regs_pkg::sample_t sample_in = '0;
  option_regs_pkg::link_cmd_t link_cmd;
  option_regs_pkg::link_rsp_t link_rsp;
  option_regs_pkg::telemetry_t readings;
  option_regs_pkg::divider_t vout_adc_divider_select;
  option_regs_pkg::misc_t misc_options;
  int num_errors = 0, tests_run = 0;

  always #50 clk = ~clk;
  initial #37 forever #62.5 link_clk = ~link_clk;
  option_regs DUT (.*);
  link_host_model host (.link_clk(link_clk), .link_ready(link_ready), .link_rsp(link_rsp), .link_cmd(link_cmd));

  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic near(string what, logic [15:0] exp, logic [15:0] got);
    chk(what, exp, (got >= exp - (exp >> 3) && got <= exp + (exp >> 3)) ? exp : got);
  endtask
  task automatic wr(logic [7:0] c, logic [15:0] d);
    host.xfer(1'b1, c, d, rd, nack);
    chk("write ack", 0, nack);
  endtask
  task automatic rdchk(string what, logic [7:0] c, logic [15:0] e);
    host.xfer(1'b0, c, 16'h0000, rd, nack);
    chk(what, {1'b0, e}, {nack, rd});
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic smp(logic [1:0] k, logic [15:0] d, int n);
    repeat (n) begin
      @(negedge clk) sample_in = {1'b1, k, d};
      @(negedge clk) sample_in.valid = 1'b0;
    end
    cyc(1);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs;
    rdchk("options reset", `CMD_OPTIONS, `OPT_RESET);
    rdchk("misc reset", `CMD_MISC, `MISC_RESET);
    chk("misc reset fields", 7'h6B, misc_options);
    chk("margin reset", {`MLO_VAL0, `MHI_VAL0}, {margin_low_restore, margin_high_restore});
    wr(`CMD_OPTIONS, 16'hFFFF);
    chk("pins", 4'hF, {negative_limit_disable, limit_override, voltage_only_measure, telemetry_adc_enable});
    rdchk("options mask", `CMD_OPTIONS, `OPT_WMASK);
    wr(`CMD_MISC, 16'hFFFF);
    rdchk("misc mask", `CMD_MISC, `MISC_WMASK);
    chk("misc fields", 7'h7F, misc_options);
    chk("margin set", {`MLO_VAL1, `MHI_VAL1}, {margin_low_restore, margin_high_restore});
    host.xfer(1'b1, `CMD_READ_VOUT, 16'h0000, rd, nack);
    chk("read-only nack", 1, nack);
    $display("t_regs done");
  endtask
  task automatic t_pin;
    wr(`CMD_OPTIONS, 16'h0004);
    power_good_out_raw = 1;
    cyc(5);
    chk("pin as good", 1, reset_or_good_pin);
    wr(`CMD_OPTIONS, 16'h0006);
    reset_req_raw = 1;
    cyc(5);
    chk("pin as reset", 0, reset_or_good_pin);
    power_good_out_raw = 0;
    reset_req_raw = 0;
    cyc(5);
    chk("pin reset released", 1, reset_or_good_pin);
    $display("t_pin done");
  endtask
  task automatic t_avg;
    logic [1:0] code [4] = '{`AVG_BYPASS, `AVG_8, `AVG_16, `AVG_32};
    int depth [4] = '{1, 8, 16, 32};
    for (int i = 0; i < 4; i++) begin
      wr(`CMD_OPTIONS, {9'h000, code[i], 5'h0C});
      wr(`CMD_OPTIONS, {9'h000, code[i], 5'h04});
      smp(`CH_VOUT, 16'h0800, depth[i]);
      near("first average", 16'h0800, readings.vout);
      smp(`CH_VOUT, 16'h0400, depth[i] - 1);
      near("partial window", 16'h0800, readings.vout);
      smp(`CH_VOUT, 16'h0400, 1);
      chk("full window", 16'h0400, readings.vout);
    end
    $display("t_avg done");
  endtask
  task automatic t_adc;
    wr(`CMD_OPTIONS, 16'h0020);
    chk("adc off", 0, telemetry_adc_enable);
    smp(`CH_VOUT, 16'h0123, 1);
    chk("frozen vout", 16'h0400, readings.vout);
    wr(`CMD_OPTIONS, 16'h002C);
    smp(`CH_IOUT, 16'h0055, 1);
    smp(`CH_TEMP, 16'h0066, 1);
    smp(`CH_VOUT, 16'h0077, 1);
    chk("voltage only", {16'h0077, 32'h0}, readings);
    rdchk("vout read", `CMD_READ_VOUT, 16'h0077);
    wr(`CMD_OPTIONS, 16'h0024);
    smp(`CH_IOUT, 16'h0055, 1);
    smp(`CH_TEMP, 16'h0066, 1);
    chk("all channels", {16'h0077, 16'h0055, 16'h0066}, readings);
    $display("t_adc done");
  endtask
  task automatic t_store;
    wr(`CMD_OPTIONS, 16'h0044);
    wr(`CMD_STORE_ALL, 16'h0000);
    wr(`CMD_OPTIONS, 16'h001C);
    wr(`CMD_RESTORE_ALL, 16'h0000);
    rdchk("restored word", `CMD_OPTIONS, 16'h005C);
    $display("t_store done");
  endtask
  task automatic t_div;
    logic [11:0] rg = 12'h01B, sc = 12'h902, ex = 12'hD34;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk) vout_scale_loop = sc[2*i +: 2];
      wr(`CMD_OPTIONS, {6'h00, rg[2*i +: 2], 8'h04});
      cyc(2);
      chk("divider", ex[2*i +: 2], vout_adc_divider_select);
    end
    $display("t_div done");
  endtask
  task automatic t_faults;
    wr(`CMD_OPTIONS, 16'h0894);
    @(negedge clk) write_check_fail = 1;
    @(negedge clk) write_check_fail = 0;
    wr(`CMD_OPTIONS, 16'h0884);
    cyc(2);
    chk("override quiet", 0, {invalid_data_flag, smbalert_active});
    @(negedge clk) write_check_fail = 1;
    @(negedge clk) write_check_fail = 0;
    cyc(1);
    chk("checked write", 2'h3, {invalid_data_flag, smbalert_active});
    @(negedge clk) clear_faults = 1;
    @(negedge clk) clear_faults = 0;
    fault_active = 8'h05;
    cyc(2);
    chk("fault alert", 1, smbalert_active);
    @(negedge clk) ara_done = 1;
    @(negedge clk) ara_done = 0;
    cyc(1);
    chk("auto mask", {8'h05, 1'b0}, {fault_mask, smbalert_active});
    wr(`CMD_OPTIONS, 16'h0804);
    @(negedge clk) clear_faults = 1;
    @(negedge clk) clear_faults = 0;
    @(negedge clk) ara_done = 1;
    @(negedge clk) ara_done = 0;
    cyc(1);
    chk("no auto mask", {8'h00, 1'b1}, {fault_mask, smbalert_active});
    @(negedge clk) host_mask_set = 8'h05;
    @(negedge clk) host_mask_set = 8'h00;
    cyc(1);
    chk("host mask", {8'h05, 1'b0}, {fault_mask, smbalert_active});
    @(negedge clk) shutdown_event = 1;
    @(negedge clk) shutdown_event = 0;
    chk("restore pulse", 1, vout_command_restore);
    wr(`CMD_OPTIONS, 16'h0004);
    @(negedge clk) shutdown_event = 1;
    @(negedge clk) shutdown_event = 0;
    chk("no restore", 0, vout_command_restore);
    $display("t_faults done");
  endtask

  initial begin
    #2000000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1;
    t_regs;
    t_pin;
    t_avg;
    t_adc;
    t_store;
    t_div;
    t_faults;
    close_out;
  end
endmodule
